// ---- design/lmfc_align_pkg.sv ----
package lmfc_align_pkg;

	// ****************
	// Register port
	// ****************
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_PULSE_DELAY_COUNT = 12'h035;
	localparam logic [11:0] OFS_PULSE_REFERENCE_COUNT = 12'h036;
	localparam logic [11:0] OFS_LAST_PHASE_ERROR_LOW = 12'h038;
	localparam logic [11:0] OFS_LAST_PHASE_ERROR_HIGH = 12'h039;
	localparam logic [11:0] OFS_ALIGN_CONTROL = 12'h03A;
	localparam logic [11:0] OFS_ALIGN_STATUS = 12'h03B;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************
	// Field positions
	// ****************
	localparam int BIT_ALIGN_ENABLE = 7;
	localparam int BIT_ARM_STROBE = 6;
	localparam int BIT_CLEAR_STICKY = 5;
	localparam int BIT_CLEAR_LAST = 4;
	localparam int BIT_LAST_BELOW = 7;
	localparam int BIT_LAST_ABOVE = 6;
	localparam int BIT_LAST_MSB = 0;
	localparam int BIT_BUSY = 7;
	localparam int BIT_LOCKED = 3;
	localparam int BIT_ROTATED = 2;
	localparam int BIT_TRIPPED = 0;

	// ****************
	// Modes and states
	// ****************
	localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
	localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
	localparam logic [3:0] MODE_MONITOR = 4'h8;
	localparam logic [3:0] MODE_ONE_SHOT_MONITOR = 4'h9;
	localparam int LMFC_PERIOD_DEFAULT = 16;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_REFS = 2'b10,
		ST_MONITOR = 2'b11
	} align_state_t;

endpackage

// ---- design/level_sync.sv ----
`timescale 1ns/1ps

module level_sync (
	input wire logic clock,
	input wire logic reset,
	input wire logic async_in,
	output logic sync_out
);

	logic stage1;

	// ****************
	// Two flop synchroniser
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ---- design/lmfc_sysref_sync_aligner.sv ----
`timescale 1ns/1ps

// Functional notes
// - Pulse mode waits the programmed number of LMFC periods before a sync cycle.
// - Rotation happens only after the programmed count of SYSREF pulses.
// - Last phase error is 9 bits; low byte in one register, bit 8 next.
// - Last-under flag at bit 7 marks error below the window.
// - Last-over flag at bit 6 marks error above the window.
// - Logic runs only when enabled; mode picks one-shot, continuous, monitor, one-shot-monitor.
// - Software arms one-shot by the arm bit; next qualifying SYSREF is acted on.
// - Rising edge of control bit 5 clears rotated and tripped sticky bits.
// - Rising edge of control bit 4 clears last error and its flags.
// - Status bit 7 shows the state machine busy.
// - Status bit 3 shows LMFC aligned within the error window.
// - Status bit 2 is sticky, set whenever clocks are rotated.
// - Status bit 0 is sticky, set on a SYSREF pulse after arming.
// - Phase deviations within plus or minus window clocks cause no adjustment.
module lmfc_sysref_sync_aligner #(
	parameter int LMFC_PERIOD = lmfc_align_pkg::LMFC_PERIOD_DEFAULT
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic sysref,
	input wire logic [2:0] phase_tolerance_window,
	input wire logic [11:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_write_data,
	output logic [7:0] reg_read_data,
	output logic [7:0] lmfc_count,
	output logic lmfc_edge
);

	// ****************
	// Registers
	// ****************
	logic [7:0] pulse_delay_periods;
	logic [7:0] pulse_ref_pulses;
	logic [7:0] align_control;
	logic [7:0] last_err_low_bits;
	logic last_err_msb;
	logic last_err_below_window;
	logic last_err_above_window;
	logic align_locked;
	logic align_rotated_sticky;
	logic align_tripped_sticky;
	logic [7:0] prev_control;
	logic [8:0] present_phase_error;
	lmfc_align_pkg::align_state_t state;
	logic [7:0] delay_cnt;
	logic [7:0] ref_cnt;
	logic sysref_level;
	logic sysref_prev;

	logic align_enable;
	logic [3:0] align_mode_select;
	logic arm_rise;
	logic clear_sticky_flags;
	logic clear_last_error;
	logic sysref_edge;
	logic lmfc_wrap;
	logic [8:0] phase_err;
	logic [8:0] window9;
	logic err_over;
	logic err_under;
	logic ref_reached;
	logic act;
	logic do_rotate;
	logic monitor_act;
	logic align_machine_busy;
	logic [7:0] next_read_data;

	assign align_enable = align_control[lmfc_align_pkg::BIT_ALIGN_ENABLE];
	assign align_mode_select = align_control[3:0];
	assign arm_rise = align_control[lmfc_align_pkg::BIT_ARM_STROBE]
		& ~prev_control[lmfc_align_pkg::BIT_ARM_STROBE];
	assign clear_sticky_flags = align_control[lmfc_align_pkg::BIT_CLEAR_STICKY]
		& ~prev_control[lmfc_align_pkg::BIT_CLEAR_STICKY];
	assign clear_last_error = align_control[lmfc_align_pkg::BIT_CLEAR_LAST]
		& ~prev_control[lmfc_align_pkg::BIT_CLEAR_LAST];
	assign sysref_edge = sysref_level & ~sysref_prev;
	assign lmfc_wrap = lmfc_count == 8'(LMFC_PERIOD - 1);
	assign align_machine_busy = (state == lmfc_align_pkg::ST_DELAY)
		|| (state == lmfc_align_pkg::ST_REFS);

	level_sync u_sysref_sync (
		.clock(clock),
		.reset(reset),
		.async_in(sysref),
		.sync_out(sysref_level)
	);

	// ****************
	// Phase error
	// ****************
	always_comb begin
		if (lmfc_count <= 8'(LMFC_PERIOD / 2)) begin
			phase_err = {1'b0, lmfc_count};
		end else begin
			phase_err = {1'b0, lmfc_count} - 9'(LMFC_PERIOD);
		end
	end

	assign window9 = {6'h00, phase_tolerance_window};
	assign err_over = $signed(phase_err) > $signed(window9);
	assign err_under = $signed(phase_err) < -$signed(window9);
	assign ref_reached = ({1'b0, ref_cnt} + 9'h001) >= {1'b0, pulse_ref_pulses};
	assign act = align_enable && (state == lmfc_align_pkg::ST_REFS)
		&& sysref_edge && ref_reached;
	assign do_rotate = act && (err_over || err_under);
	assign monitor_act = align_enable && (state == lmfc_align_pkg::ST_MONITOR) && sysref_edge;

	// ****************
	// Register writes
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			pulse_delay_periods <= lmfc_align_pkg::REG_RESET;
			pulse_ref_pulses <= lmfc_align_pkg::REG_RESET;
			align_control <= lmfc_align_pkg::REG_RESET;
			prev_control <= lmfc_align_pkg::REG_RESET;
		end else begin
			prev_control <= align_control;
			if (reg_write) begin
				case (reg_addr)
					lmfc_align_pkg::OFS_PULSE_DELAY_COUNT: begin
						pulse_delay_periods <= reg_write_data;
					end
					lmfc_align_pkg::OFS_PULSE_REFERENCE_COUNT: begin
						pulse_ref_pulses <= reg_write_data;
					end
					lmfc_align_pkg::OFS_ALIGN_CONTROL: begin
						align_control <= reg_write_data;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ****************
	// Register reads
	// ****************
	always_comb begin
		case (reg_addr)
			lmfc_align_pkg::OFS_PULSE_DELAY_COUNT: next_read_data = pulse_delay_periods;
			lmfc_align_pkg::OFS_PULSE_REFERENCE_COUNT: next_read_data = pulse_ref_pulses;
			lmfc_align_pkg::OFS_LAST_PHASE_ERROR_LOW: next_read_data = last_err_low_bits;
			lmfc_align_pkg::OFS_LAST_PHASE_ERROR_HIGH: begin
				next_read_data = {last_err_below_window, last_err_above_window, 5'h00,
					last_err_msb};
			end
			lmfc_align_pkg::OFS_ALIGN_CONTROL: next_read_data = align_control;
			lmfc_align_pkg::OFS_ALIGN_STATUS: begin
				next_read_data = {align_machine_busy, 3'h0, align_locked,
					align_rotated_sticky, 1'b0, align_tripped_sticky};
			end
			default: next_read_data = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reg_read_data <= 8'h00;
		end else begin
			reg_read_data <= next_read_data;
		end
	end

	// ****************
	// LMFC counter
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			lmfc_count <= 8'h00;
			lmfc_edge <= 1'b0;
		end else if (do_rotate) begin
			lmfc_count <= 8'h01;
			lmfc_edge <= 1'b0;
		end else begin
			lmfc_count <= lmfc_wrap ? 8'h00 : lmfc_count + 8'h01;
			lmfc_edge <= (lmfc_count == 8'(LMFC_PERIOD - 2));
		end
	end

	// ****************
	// Sync state machine
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			state <= lmfc_align_pkg::ST_IDLE;
			delay_cnt <= 8'h00;
			ref_cnt <= 8'h00;
			sysref_prev <= 1'b0;
		end else begin
			sysref_prev <= sysref_level;
			if (!align_enable) begin
				state <= lmfc_align_pkg::ST_IDLE;
			end else begin
				case (state)
					lmfc_align_pkg::ST_IDLE: begin
						delay_cnt <= 8'h00;
						ref_cnt <= 8'h00;
						if (align_mode_select == lmfc_align_pkg::MODE_CONTINUOUS) begin
							state <= lmfc_align_pkg::ST_DELAY;
						end else if (align_mode_select == lmfc_align_pkg::MODE_MONITOR) begin
							state <= lmfc_align_pkg::ST_MONITOR;
						end else if (arm_rise && (align_mode_select
							== lmfc_align_pkg::MODE_ONE_SHOT || align_mode_select
							== lmfc_align_pkg::MODE_ONE_SHOT_MONITOR)) begin
							state <= lmfc_align_pkg::ST_DELAY;
						end
					end
					lmfc_align_pkg::ST_DELAY: begin
						if (delay_cnt >= pulse_delay_periods) begin
							state <= lmfc_align_pkg::ST_REFS;
							ref_cnt <= 8'h00;
						end else if (lmfc_wrap) begin
							delay_cnt <= delay_cnt + 8'h01;
						end
					end
					lmfc_align_pkg::ST_REFS: begin
						if (act) begin
							delay_cnt <= 8'h00;
							if (align_mode_select == lmfc_align_pkg::MODE_CONTINUOUS) begin
								state <= lmfc_align_pkg::ST_DELAY;
							end else if (align_mode_select
								== lmfc_align_pkg::MODE_ONE_SHOT_MONITOR) begin
								state <= lmfc_align_pkg::ST_MONITOR;
							end else begin
								state <= lmfc_align_pkg::ST_IDLE;
							end
						end else if (sysref_edge) begin
							ref_cnt <= ref_cnt + 8'h01;
						end
					end
					lmfc_align_pkg::ST_MONITOR: begin
						if (align_mode_select != lmfc_align_pkg::MODE_MONITOR
							&& align_mode_select != lmfc_align_pkg::MODE_ONE_SHOT_MONITOR) begin
							state <= lmfc_align_pkg::ST_IDLE;
						end
					end
					default: state <= lmfc_align_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ****************
	// Error capture and status
	// ****************
	always_ff @(posedge clock) begin
		if (reset) begin
			present_phase_error <= 9'h000;
			last_err_low_bits <= 8'h00;
			last_err_msb <= 1'b0;
			last_err_below_window <= 1'b0;
			last_err_above_window <= 1'b0;
			align_locked <= 1'b0;
		end else begin
			if (do_rotate) begin
				last_err_low_bits <= phase_err[7:0];
				last_err_msb <= phase_err[8];
				last_err_below_window <= err_under;
				last_err_above_window <= err_over;
				present_phase_error <= 9'h000;
			end else begin
				if (clear_last_error) begin
					last_err_low_bits <= 8'h00;
					last_err_msb <= 1'b0;
					last_err_below_window <= 1'b0;
					last_err_above_window <= 1'b0;
				end
				if (act || monitor_act) begin
					present_phase_error <= phase_err;
				end
			end
			if (!align_enable) begin
				align_locked <= 1'b0;
			end else if (act) begin
				align_locked <= 1'b1;
			end else if (monitor_act) begin
				align_locked <= !(err_over || err_under);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			align_rotated_sticky <= 1'b0;
			align_tripped_sticky <= 1'b0;
		end else begin
			if (do_rotate) begin
				align_rotated_sticky <= 1'b1;
			end else if (clear_sticky_flags) begin
				align_rotated_sticky <= 1'b0;
			end
			if (align_enable && state == lmfc_align_pkg::ST_REFS && sysref_edge) begin
				align_tripped_sticky <= 1'b1;
			end else if (clear_sticky_flags) begin
				align_tripped_sticky <= 1'b0;
			end
		end
	end

	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_arm_taken;
		state == lmfc_align_pkg::ST_IDLE && align_enable && arm_rise
			&& align_mode_select == lmfc_align_pkg::MODE_ONE_SHOT;
	endsequence
	sequence s_enter_delay;
		##1 state == lmfc_align_pkg::ST_DELAY;
	endsequence

	AST_DELAY_GATE: assert property (state == lmfc_align_pkg::ST_DELAY && align_enable
		&& delay_cnt < pulse_delay_periods |=> state != lmfc_align_pkg::ST_REFS)
		else $error("sync cycle active before delay elapsed");
	AST_REF_COUNT: assert property (align_enable && state == lmfc_align_pkg::ST_REFS
		&& sysref_edge && !ref_reached
		|=> state == lmfc_align_pkg::ST_REFS && ref_cnt == $past(ref_cnt) + 8'h01)
		else $error("acted before reference count reached");
	AST_LAST_ERR: assert property (do_rotate |=> {last_err_msb, last_err_low_bits}
		== $past(phase_err) && present_phase_error == 9'h000)
		else $error("last error not captured on rotate");
	AST_UNDER: assert property (do_rotate |=> last_err_below_window == $past(err_under))
		else $error("under flag wrong");
	AST_OVER: assert property (do_rotate |=> last_err_above_window == $past(err_over))
		else $error("over flag wrong");
	AST_DISABLED: assert property (!align_enable |=> state == lmfc_align_pkg::ST_IDLE)
		else $error("state machine ran while disabled");
	AST_ARM: assert property (s_arm_taken |-> s_enter_delay)
		else $error("arm not taken");
	AST_CLR_STICKY: assert property (clear_sticky_flags && !do_rotate && !sysref_edge
		|=> !align_rotated_sticky && !align_tripped_sticky)
		else $error("sticky bits not cleared");
	AST_CLR_LAST: assert property (clear_last_error && !do_rotate
		|=> {last_err_below_window, last_err_above_window, last_err_msb, last_err_low_bits}
		== 11'h000)
		else $error("last error not cleared");
	AST_BUSY: assert property (s_arm_taken ##1 1'b1 |-> align_machine_busy)
		else $error("busy not shown");
	AST_LOCK: assert property (act |=> align_locked)
		else $error("lock not set after sync");
	AST_ROTATE: assert property (do_rotate |=> align_rotated_sticky && lmfc_count == 8'h01)
		else $error("rotation not recorded");
	AST_TRIP: assert property (align_enable && state == lmfc_align_pkg::ST_REFS
		&& sysref_edge |=> align_tripped_sticky)
		else $error("trip not recorded");
	AST_WINDOW: assert property (act && !err_over && !err_under |=> lmfc_count
		== ($past(lmfc_wrap) ? 8'h00 : $past(lmfc_count) + 8'h01))
		else $error("adjusted inside window");
	AST_RESET: assert property (disable iff (1'b0) reset |=> align_control == 8'h00
		&& state == lmfc_align_pkg::ST_IDLE && !align_locked)
		else $error("reset values wrong");

endmodule

// ---- tb/sysref_source.sv ----
`timescale 1ns/1ps

// ****************
// SYSREF source
// ****************
module sysref_source #(
	parameter int PULSE_CYCLES = 4
) (
	input wire logic clock,
	input wire logic fire,
	output logic sysref
);
	int left = 0;

	// Pulse of a few clocks, pin low between pulses
	always @(posedge clock) begin
		if (fire) begin
			left <= PULSE_CYCLES;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end

	assign sysref = (left > 0);
endmodule

// ---- tb/lmfc_sysref_sync_aligner_test.sv ----
`timescale 1ns/1ps

module lmfc_sysref_sync_aligner_test;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic fire = 1'b0;
	logic sysref;
	logic [2:0] window = 3'h0;
	logic [11:0] reg_addr = 12'h000;
	logic reg_write = 1'b0;
	logic [7:0] reg_write_data = 8'h00;
	logic [7:0] reg_read_data;
	logic [7:0] lmfc_count;
	logic lmfc_edge;
	logic [7:0] s;
	int n_errors = 0;
	int compares = 0;

	// ****************
	// Clock, DUT, far side
	// ****************
	initial begin
		forever #20 clock = ~clock;
	end

	lmfc_sysref_sync_aligner #(.LMFC_PERIOD(16)) i_dut (
		.clock(clock),
		.reset(reset),
		.sysref(sysref),
		.phase_tolerance_window(window),
		.reg_addr(reg_addr),
		.reg_write(reg_write),
		.reg_write_data(reg_write_data),
		.reg_read_data(reg_read_data),
		.lmfc_count(lmfc_count),
		.lmfc_edge(lmfc_edge)
	);

	sysref_source i_src (
		.clock(clock),
		.fire(fire),
		.sysref(sysref)
	);

	// ****************
	// Shared tasks
	// ****************
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_write_data = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		@(negedge clock);
		d = reg_read_data;
	endtask

	// Arm by a low then a high write of the strobe
	task automatic arm_one_shot();
		wr(12'h03A, 8'h81);
		wr(12'h03A, 8'hC1);
	endtask

	task automatic fire_at(input logic [7:0] c);
		int n;
		n = 0;
		@(negedge clock);
		while (lmfc_count !== c && n < 64) begin
			@(negedge clock);
			n++;
		end
		check("fire phase", lmfc_count, c);
		fire = 1'b1;
		@(negedge clock);
		fire = 1'b0;
		repeat (12) @(negedge clock);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset_and_access();
		logic [11:0] a;
		for (int i = 0; i < 7; i++) begin
			a = 12'h035 + 12'(i);
			rd(a, s);
			check("reset value", s, 8'h00);
		end
		wr(12'h035, 8'hA5);
		rd(12'h035, s);
		check("delay count", s, 8'hA5);
		wr(12'h036, 8'h5A);
		rd(12'h036, s);
		check("ref count", s, 8'h5A);
		wr(12'h039, 8'hFF);
		rd(12'h039, s);
		check("last high ro", s, 8'h00);
		wr(12'h03B, 8'hFF);
		rd(12'h03B, s);
		check("status ro", s, 8'h00);
		wr(12'h035, 8'h00);
		wr(12'h036, 8'h00);
	endtask

	task automatic t_modes_disabled();
		logic [7:0] modes [4];
		modes = '{8'h01, 8'h02, 8'h08, 8'h09};
		foreach (modes[i]) begin
			wr(12'h03A, modes[i]);
			rd(12'h03A, s);
			check("mode", s, modes[i]);
		end
		wr(12'h03A, 8'h01);
		wr(12'h03A, 8'h41);
		fire_at(8'd3);
		rd(12'h03B, s);
		check("disabled status", s, 8'h00);
	endtask

	task automatic t_one_shot_over();
		window = 3'h0;
		arm_one_shot();
		rd(12'h03B, s);
		check("busy", s, 8'h80);
		fire_at(8'd3);
		rd(12'h03B, s);
		check("status after shot", s, 8'h0D);
		rd(12'h038, s);
		check("last low", s, 8'h06);
		rd(12'h039, s);
		check("last high", s, 8'h40);
	endtask

	task automatic t_clears();
		wr(12'h03A, 8'h81);
		wr(12'h03A, 8'hA1);
		rd(12'h03B, s);
		check("sticky cleared", s, 8'h08);
		wr(12'h03A, 8'h81);
		wr(12'h03A, 8'h91);
		rd(12'h038, s);
		check("last low cleared", s, 8'h00);
		rd(12'h039, s);
		check("last high cleared", s, 8'h00);
	endtask

	task automatic t_one_shot_under();
		arm_one_shot();
		fire_at(8'd9);
		rd(12'h038, s);
		check("neg last low", s, 8'hFC);
		rd(12'h039, s);
		check("neg last high", s, 8'h81);
	endtask

	task automatic t_within_window();
		wr(12'h03A, 8'h81);
		wr(12'h03A, 8'hA1);
		window = 3'h7;
		arm_one_shot();
		fire_at(8'd1);
		rd(12'h03B, s);
		check("inside window", s, 8'h09);
		rd(12'h038, s);
		check("last kept", s, 8'hFC);
	endtask

	task automatic t_pulse_counts();
		window = 3'h0;
		wr(12'h035, 8'h03);
		wr(12'h036, 8'h02);
		arm_one_shot();
		fire_at(8'd3);
		rd(12'h03B, s);
		check("delay pending", s & 8'h84, 8'h80);
		repeat (60) @(negedge clock);
		fire_at(8'd3);
		rd(12'h03B, s);
		check("one ref pulse", s & 8'h84, 8'h80);
		fire_at(8'd3);
		rd(12'h03B, s);
		check("second ref pulse", s & 8'h84, 8'h04);
	endtask

	// Edge flag marks the last count of each period
	task automatic t_lmfc_edge();
		int n;
		n = 0;
		@(negedge clock);
		while (lmfc_count !== 8'h0E && n < 64) begin
			@(negedge clock);
			n++;
		end
		check("before last", lmfc_count, 8'h0E);
		check("edge before last", {7'h00, lmfc_edge}, 8'h00);
		@(negedge clock);
		check("lmfc last", lmfc_count, 8'h0F);
		check("edge at last", {7'h00, lmfc_edge}, 8'h01);
		@(negedge clock);
		check("lmfc wrap", lmfc_count, 8'h00);
		check("edge after wrap", {7'h00, lmfc_edge}, 8'h00);
	endtask

	task automatic t_continuous_monitor();
		wr(12'h035, 8'h00);
		wr(12'h036, 8'h00);
		window = 3'h0;
		wr(12'h03A, 8'h82);
		fire_at(8'h03);
		rd(12'h03B, s);
		check("continuous status", s, 8'h8D);
		rd(12'h038, s);
		check("continuous first", s, 8'h06);
		fire_at(8'h05);
		rd(12'h038, s);
		check("continuous again", s, 8'h08);
		wr(12'h03A, 8'h08);
		wr(12'h03A, 8'h88);
		fire_at(8'h03);
		rd(12'h03B, s);
		check("monitor outside", s, 8'h05);
		rd(12'h038, s);
		check("monitor keeps last", s, 8'h08);
		window = 3'h7;
		fire_at(8'h03);
		rd(12'h03B, s);
		check("monitor inside", s, 8'h0D);
		window = 3'h0;
		wr(12'h03A, 8'h09);
		wr(12'h03A, 8'h89);
		wr(12'h03A, 8'hC9);
		fire_at(8'h09);
		rd(12'h03B, s);
		check("shot then monitor", s, 8'h0D);
		rd(12'h039, s);
		check("shot then monitor high", s, 8'h81);
		fire_at(8'h03);
		rd(12'h03B, s);
		check("monitor after shot", s, 8'h05);
	endtask

	task automatic t_mid_reset();
		@(negedge clock);
		reset = 1'b1;
		repeat (2) @(negedge clock);
		reset = 1'b0;
		rd(12'h03A, s);
		check("control after reset", s, 8'h00);
		rd(12'h03B, s);
		check("status after reset", s, 8'h00);
		rd(12'h038, s);
		check("last low after reset", s, 8'h00);
	endtask

	// ****************
	// Main sequence and watchdog
	// ****************
	initial begin
		repeat (16) @(negedge clock);
		reset = 1'b0;
		t_reset_and_access();
		t_lmfc_edge();
		t_modes_disabled();
		t_one_shot_over();
		t_clears();
		t_one_shot_under();
		t_within_window();
		t_pulse_counts();
		t_continuous_monitor();
		t_mid_reset();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		close_out();
	end
endmodule
